// file: bus_timeout_timer.sv
`timescale 1ns/10ps
module bus_timeout_timer
   import xbus_ctrl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // control
   input wire logic [3:0] limit,
   input wire logic system_controller,
   input wire logic cycle_start,
   input wire logic cycle_done,
   // result
   output logic bus_error_line
);
   typedef enum logic [1:0] {idle = 2'b00, timing = 2'b01, fault = 2'b10} tmr_state_e;
   tmr_state_e state, next_state;
   logic [timeout_cnt_w-1:0] count, next_count;
   logic [timeout_cnt_w-1:0] limit_cycles;
   logic next_err;

   // code to cycle count; lookup kept as constants so it synthesizes to a rom
   always_comb
   begin
      limit_cycles = timeout_cnt_w'(timeout_us[limit] * clk_mhz);
   end

   // bus error holds until the cycle ends, so the master sees it
   always_comb
   begin
      next_state = state;
      next_count = count;
      next_err = 1'b0;
      case (state)
         idle:
         begin
            if (cycle_start && system_controller && limit != 4'h0)
            begin
               next_state = timing;
               next_count = '0;
            end
         end
         timing:
         begin
            if (cycle_done || limit == 4'h0)
               next_state = idle;
            else if (cycle_start)
               next_count = '0;
            else if (count + 1'b1 >= limit_cycles)
               next_state = fault;
            else
               next_count = count + 1'b1;
         end
         fault:
         begin
            next_err = 1'b1;
            if (cycle_done)
            begin
               next_state = idle;
               next_err = 1'b0;
            end
         end
         default: next_state = idle;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= idle;
         count <= '0;
         bus_error_line <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         bus_error_line <= (next_state == fault) ? 1'b1 : next_err;
      end
   end
endmodule

// file: expansion_bus_shared_control.sv
`timescale 1ns/10ps
module expansion_bus_shared_control
   import xbus_ctrl_pkg::*;
(
   // clock and hard reset
   input wire logic sys_clk,
   input wire logic nrst,
   // soft reset pulse, same clock
   input wire logic soft_reset,
   // eeprom values, sampled at hard reset release
   input wire eeprom_cfg_s eeprom_cfg,
   // register access, offset within the A24/A32 window
   input wire logic [11:0] reg_addr,
   input wire logic reg_write,
   input wire logic [3:0] reg_byte_en,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // expansion bus cycle status, from pins
   input wire logic system_controller,
   input wire logic cycle_start,
   input wire logic cycle_done,
   // controls to the bus logic
   output logic dma1_burst_select,
   output logic dma2_burst_select,
   output logic fair_requester,
   output logic parity_check_enable,
   output logic bus_error_line
);
   ctrl_s ctrl, next_ctrl;
   logic load_pending, next_load_pending;
   localparam int n_pins = 3;
   logic [n_pins-1:0] pin_raw;
   wire logic [n_pins-1:0] pin_q;
   logic start_prev;
   logic start_pulse;
   logic hit;
   logic [31:0] wmask;

   // pins gathered so each one gets the same filter: start, done, system controller
   assign pin_raw = {system_controller, cycle_done, cycle_start};

   // pins pass three stage flops and an output flop; a change counts once stages two and three agree
   for (genvar i = 0; i < n_pins; i++)
   begin : g_sync
      logic [2:0] stages;
      logic q;
      always_ff @(posedge sys_clk or negedge nrst)
      begin
         if (!nrst)
         begin
            stages <= 3'h0;
            q <= 1'b0;
         end
         else
         begin
            stages <= {stages[1:0], pin_raw[i]};
            if (stages[2] == stages[1])
               q <= stages[2];
         end
      end
      assign pin_q[i] = q;
   end

   // previous start level; resets to the idle level of the pin so no false edge
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         start_prev <= 1'b0;
      else
         start_prev <= pin_q[0];
   end

   // one pulse per cycle start: a held level would keep restarting the timer
   always_comb
   begin
      start_pulse = pin_q[0] && !start_prev;
   end

   // byte enables widened to a bit mask for partial writes
   always_comb
   begin
      hit = (reg_addr == shared_bus_control_offset);
      wmask = {{8{reg_byte_en[3]}}, {8{reg_byte_en[2]}}, {8{reg_byte_en[1]}},
         {8{reg_byte_en[0]}}};
   end

   // register update; eeprom load happens one cycle after hard reset release
   // because an async reset may only load constants
   always_comb
   begin
      next_ctrl = ctrl;
      next_load_pending = 1'b0;
      if (load_pending)
      begin
         next_ctrl.fair = eeprom_cfg.fair;
         next_ctrl.parity = eeprom_cfg.parity;
         next_ctrl.limit = eeprom_cfg.limit;
      end
      else if (reg_write && hit)
      begin
         // a written one takes the polarity; a written zero leaves the bit alone
         if (wmask[bit_dma2_burst] && reg_wdata[bit_dma2_burst])
            next_ctrl.dma2_burst = reg_wdata[bit_write_polarity];
         if (wmask[bit_dma1_burst] && reg_wdata[bit_dma1_burst])
            next_ctrl.dma1_burst = reg_wdata[bit_write_polarity];
         if (wmask[bit_fair])
            next_ctrl.fair = reg_wdata[bit_fair];
         if (wmask[bit_parity])
            next_ctrl.parity = reg_wdata[bit_parity];
         if (wmask[timeout_lsb])
            next_ctrl.limit = reg_wdata[timeout_lsb +: 4];
      end
      // soft_reset touches none of these fields: burst selects survive it
      if (soft_reset)
         next_ctrl.dma2_burst = next_ctrl.dma2_burst;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl <= '{dma2_burst: 1'b0, dma1_burst: 1'b0, fair: 1'b0, parity: 1'b0,
            limit: timeout_default};
         load_pending <= 1'b1;
      end
      else
      begin
         ctrl <= next_ctrl;
         load_pending <= next_load_pending;
      end
   end

   // readback: reserved ones shown as one, polarity bit reads zero
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         reg_rdata <= 32'h0000_0000;
      else if (hit)
      begin
         reg_rdata <= reserved_ones;
         reg_rdata[bit_dma2_burst] <= ctrl.dma2_burst;
         reg_rdata[bit_dma1_burst] <= ctrl.dma1_burst;
         reg_rdata[bit_fair] <= ctrl.fair;
         reg_rdata[bit_parity] <= ctrl.parity;
         reg_rdata[timeout_lsb +: 4] <= ctrl.limit;
      end
      else
         reg_rdata <= 32'h0000_0000;
   end

   // control outputs straight from the register
   always_comb
   begin
      dma1_burst_select = ctrl.dma1_burst;
      dma2_burst_select = ctrl.dma2_burst;
      fair_requester = ctrl.fair;
      parity_check_enable = ctrl.parity;
   end

   bus_timeout_timer u_timer (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .limit(ctrl.limit),
      .system_controller(pin_q[2]),
      .cycle_start(start_pulse),
      .cycle_done(pin_q[1]),
      .bus_error_line(bus_error_line)
   );
endmodule

// file: expansion_bus_shared_control_tb_top.sv
`timescale 1ns/10ps
module expansion_bus_shared_control_tb_top;
   import xbus_ctrl_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b1;
   logic soft_reset = 1'b0;
   logic reg_write = 1'b0;
   logic system_controller = 1'b1;
   logic begin_cycle = 1'b0;
   logic end_cycle = 1'b0;
   logic [3:0] reg_byte_en = 4'hF;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   eeprom_cfg_s eeprom_cfg = 6'h21;
   logic [31:0] reg_rdata;
   logic cycle_start, cycle_done, bus_error_line, dma1_burst_select;
   logic dma2_burst_select, fair_requester, parity_check_enable;
   int n_errors = 0;
   int checks_done = 0;
   always #5 sys_clk = ~sys_clk;
   expansion_bus_shared_control u_expansion_bus_shared_control (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .soft_reset(soft_reset),
      .eeprom_cfg(eeprom_cfg),
      .reg_addr(reg_addr),
      .reg_write(reg_write),
      .reg_byte_en(reg_byte_en),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .system_controller(system_controller),
      .cycle_start(cycle_start),
      .cycle_done(cycle_done),
      .dma1_burst_select(dma1_burst_select),
      .dma2_burst_select(dma2_burst_select),
      .fair_requester(fair_requester),
      .parity_check_enable(parity_check_enable),
      .bus_error_line(bus_error_line)
   );
   xbus_far_end u_xbus_far_end (
      .sys_clk(sys_clk),
      .begin_cycle(begin_cycle),
      .end_cycle(end_cycle),
      .cycle_start(cycle_start),
      .cycle_done(cycle_done)
   );
   task automatic check(logic [31:0] seen, logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         n_errors++;
         $display("Error %0t: got %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // inputs move at the falling edge, one cycle per access
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      pulse(reg_write);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] want);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      check(reg_rdata, want);
   endtask
   // the extra edge lets the eeprom load before any write
   task automatic hard_reset;
      @(negedge sys_clk);
      nrst = 1'b0;
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      @(negedge sys_clk);
   endtask
   task automatic t_burst;
      hard_reset();
      rd(12'hC40, 32'h00E1_0101);
      wr(12'hC40, 32'h38E1_0101);
      pulse(soft_reset);
      rd(12'hC40, 32'h30E1_0101);
      wr(12'hC40, 32'h20E1_0101);
      rd(12'hC40, 32'h10E1_0101);
      wr(12'hC40, 32'h28E1_0101);
      check(dma1_burst_select, 1'b1);
      check(dma2_burst_select, 1'b1);
      eeprom_cfg = 6'h18;
      hard_reset();
      rd(12'hC40, 32'h00C5_0108);
   endtask
   task automatic t_flags;
      wr(12'hC40, 32'h00E1_0100);
      check({fair_requester, parity_check_enable}, 2'b10);
      wr(12'hC44, 32'hFFFF_FFFF);
      rd(12'hC44, 32'h0000_0000);
      rd(12'hC40, 32'h00E1_0100);
   endtask
   // code 0 never fires, code 1 fires after 8 us, done clears it
   task automatic t_timer;
      int n;
      pulse(begin_cycle);
      repeat (1200) @(negedge sys_clk);
      check(bus_error_line, 1'b0);
      pulse(end_cycle);
      wr(12'hC40, 32'h00E1_0101);
      pulse(begin_cycle);
      n = 0;
      while (bus_error_line !== 1'b1 && n < 1000)
      begin
         @(negedge sys_clk);
         n++;
      end
      check(n inside {[795:815]}, 1'b1);
      pulse(end_cycle);
      repeat (8) @(negedge sys_clk);
      check(bus_error_line, 1'b0);
      pulse(begin_cycle);
      repeat (400) @(negedge sys_clk);
      pulse(end_cycle);
      repeat (800) @(negedge sys_clk);
      check(bus_error_line, 1'b0);
      system_controller = 1'b0;
      repeat (8) @(negedge sys_clk);
      pulse(begin_cycle);
      repeat (900) @(negedge sys_clk);
      check(bus_error_line, 1'b0);
      pulse(end_cycle);
      system_controller = 1'b1;
   endtask
   initial
   begin
      t_burst();
      t_flags();
      t_timer();
      test_done();
   end
   // the tests need some 4200 cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      test_done();
   end
endmodule

// file: xbus_ctrl_monitor.sv
`timescale 1ns/10ps
module xbus_ctrl_monitor
   import xbus_ctrl_pkg::*;
(
   // inputs of the block
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic soft_reset,
   input wire eeprom_cfg_s eeprom_cfg,
   input wire logic [11:0] reg_addr,
   input wire logic reg_write,
   input wire logic [3:0] reg_byte_en,
   input wire logic [31:0] reg_wdata,
   input wire logic system_controller,
   input wire logic cycle_start,
   input wire logic cycle_done,
   // outputs of the block
   input wire logic [31:0] reg_rdata,
   input wire logic dma1_burst_select,
   input wire logic dma2_burst_select,
   input wire logic fair_requester,
   input wire logic parity_check_enable,
   input wire logic bus_error_line
);
   // a taken write to this register
   wire logic hit = reg_write && reg_addr == 12'hC40;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   burst_set_a: assert property (hit && reg_byte_en[3] && reg_wdata[29]
      |=> dma2_burst_select == $past(reg_wdata[27])) else $error("burst polarity");
   burst_keep_a: assert property (hit && reg_byte_en[3] && !reg_wdata[28]
      |=> $stable(dma1_burst_select)) else $error("burst changed");
   soft_keep_a: assert property (soft_reset && !hit
      |=> $stable(dma2_burst_select)) else $error("soft reset hit burst");
   // the hard reset check must run while reset is low
   hard_clear_a: assert property (disable iff (1'b0) !nrst
      |-> !dma2_burst_select && !dma1_burst_select) else $error("burst in reset");
   fair_load_a: assert property (hit && reg_byte_en[2]
      |=> fair_requester == $past(reg_wdata[21])) else $error("fair not loaded");
   parity_load_a: assert property (hit && reg_byte_en[2]
      |=> parity_check_enable == $past(reg_wdata[18])) else $error("parity not loaded");
   unmapped_zero_a: assert property ($past(reg_addr) != 12'hC40
      |-> reg_rdata == 32'h0000_0000) else $error("unmapped read");
   done_clear_a: assert property (cycle_done [*6]
      |-> !bus_error_line) else $error("error after done");
endmodule
bind expansion_bus_shared_control xbus_ctrl_monitor u_xbus_ctrl_monitor (
   .sys_clk(sys_clk),
   .nrst(nrst),
   .soft_reset(soft_reset),
   .eeprom_cfg(eeprom_cfg),
   .reg_addr(reg_addr),
   .reg_write(reg_write),
   .reg_byte_en(reg_byte_en),
   .reg_wdata(reg_wdata),
   .system_controller(system_controller),
   .cycle_start(cycle_start),
   .cycle_done(cycle_done),
   .reg_rdata(reg_rdata),
   .dma1_burst_select(dma1_burst_select),
   .dma2_burst_select(dma2_burst_select),
   .fair_requester(fair_requester),
   .parity_check_enable(parity_check_enable),
   .bus_error_line(bus_error_line)
);

// file: xbus_ctrl_pkg.sv
package xbus_ctrl_pkg;
   localparam logic [11:0] shared_bus_control_offset = 12'hC40;
   localparam int bit_dma2_burst = 29;
   localparam int bit_dma1_burst = 28;
   localparam int bit_write_polarity = 27;
   localparam int bit_fair = 21;
   localparam int bit_parity = 18;
   localparam int timeout_lsb = 0;
   // reserved bits that read back as one
   localparam logic [31:0] reserved_ones = 32'h00C1_0100;
   localparam logic [3:0] timeout_default = 4'h8;
   localparam int clk_mhz = 100;
   // timeout limits in microseconds, indexed by code
   localparam int timeout_us [16] = '{0, 8, 15, 30, 60, 125, 250, 500,
      1000, 2000, 4000, 8000, 16000, 32000, 64000, 128000};
   localparam int timeout_cnt_w = 24;

   typedef struct packed {
      logic dma2_burst;
      logic dma1_burst;
      logic fair;
      logic parity;
      logic [3:0] limit;
   } ctrl_s;

   typedef struct packed {
      logic fair;
      logic parity;
      logic [3:0] limit;
   } eeprom_cfg_s;
endpackage

// file: xbus_far_end.sv
`timescale 1ns/10ps
module xbus_far_end (
   // clock and commands
   input wire logic sys_clk,
   input wire logic begin_cycle,
   input wire logic end_cycle,
   // cycle status levels
   output logic cycle_start = 1'b0,
   output logic cycle_done = 1'b1
);
   // a slave that never answers is just an end_cycle held off
   always @(posedge sys_clk)
   begin
      if (begin_cycle)
      begin
         cycle_start <= 1'b1;
         cycle_done <= 1'b0;
      end
      else if (end_cycle)
      begin
         cycle_start <= 1'b0;
         cycle_done <= 1'b1;
      end
   end
endmodule
